// ===== sim/discc_field_model.sv
// field side model: contacts on base inputs, volt sources on card inputs
`timescale 1ns/1ps
`default_nettype none
module discc_field_model
    import discc_pkg::*;
(
    // stimulus
    input  wire logic [NUM_INPUTS-1:0]        energize,
    // field levels
    output logic      [BASE_INPUTS-1:0]       base_level,
    output logic      [CARD_INPUTS*VOLT_W-1:0] card_volts
);
    // =====================================================================
    // sources: 200 V or 0 V, clear of both hysteresis bands and of ac act/10
    always_comb begin
        base_level = energize[BASE_INPUTS-1:0];
        for (int k = 0; k < CARD_INPUTS; k++) begin
            card_volts[k*VOLT_W +: VOLT_W] = energize[BASE_INPUTS+k] ? 9'h0C8 : 9'h000;
        end
    end
endmodule
`default_nettype wire

// ===== sim/discc_top_assertions.sv
// checker: scan timing and register bus relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module discc_top_assertions
    import discc_pkg::*;
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // consumers
    input wire logic [NUM_INPUTS-1:0] logic_state,
    input wire logic [NUM_INPUTS-1:0] output_relay_contacts,
    input wire logic                  scan_strobe,
    // axi4-lite
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // =====================================================================
    // tick spacing counter; first tick after reset has no reference
    logic [20:0] gap;
    logic        seen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap  <= 21'h0;
            seen <= 1'b0;
        end else begin
            gap  <= scan_strobe ? 21'h0 : gap + 21'h1;
            seen <= seen | scan_strobe;
        end
    end
    // =====================================================================
    // properties
    property p_tick_spacing; scan_strobe && seen |-> gap == 21'(SCAN_CYCLES - 1); endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("scan tick spacing wrong");
    property p_tick_due; seen |-> gap < 21'(SCAN_CYCLES); endproperty
    a_tick_due: assert property (p_tick_due) else $error("scan tick overdue");
    property p_tick_pulse; scan_strobe |=> !scan_strobe [*8]; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("scan strobe too long");
    property p_state_on_tick; !$past(scan_strobe) |-> $stable(logic_state); endproperty
    a_state_on_tick: assert property (p_state_on_tick) else $error("state moved off tick");
    property p_relay_on_tick; !$past(scan_strobe) |-> $stable(output_relay_contacts); endproperty
    a_relay_on_tick: assert property (p_relay_on_tick) else $error("relay moved off tick");
    property p_relay_lags; $past(scan_strobe) |-> (output_relay_contacts & ~$past(logic_state)) == '0; endproperty
    a_relay_lags: assert property (p_relay_lags) else $error("relay ahead of state");
    property p_write_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response late");
    property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_stands: assert property (p_b_stands) else $error("write response dropped");
    property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data late");
    property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_stands: assert property (p_r_stands) else $error("read data dropped");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind discc_top discc_top_assertions u_chk (.clk(clk), .rst_n(rst_n), .logic_state(logic_state),
    .output_relay_contacts(output_relay_contacts), .scan_strobe(scan_strobe), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== sim/tb_discc_top.sv
// testbench: register bus scoreboard; ticks exceed the run, so tick timing is left to the checker
`timescale 1ns/1ps
`default_nettype none
module tb_discc_top;
    import discc_pkg::*;
    typedef struct { string nm; logic [31:0] d; logic [31:0] m; logic [1:0] r; } discc_exp_t;
    logic clk = 1'b0, rst_n;
    logic [NUM_INPUTS-1:0] energize = '0;
    logic [BASE_INPUTS-1:0] base_level;
    logic [CARD_INPUTS*VOLT_W-1:0] card_volts;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fails = 0, check_count = 0;
    integer seed = 4465;
    discc_exp_t exp_r[$], exp_b[$];
    always #2.5 clk = ~clk;
    discc_field_model field_u (.energize(energize), .base_level(base_level), .card_volts(card_volts));
    discc_top dut_u (.clk(clk), .rst_n(rst_n), .base_level(base_level), .card_volts(card_volts),
        .logic_state(), .output_relay_contacts(), .scan_strobe(), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    // =====================================================================
    // reporting
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask
    task automatic cmp_read();
        discc_exp_t e;
        e = exp_r.pop_front();
        check(e.nm, e.d & e.m, s_axi_rdata & e.m);
        check({e.nm, "_rresp"}, 32'(e.r), 32'(s_axi_rresp));
    endtask
    task automatic cmp_resp();
        discc_exp_t e;
        e = exp_b.pop_front();
        check({e.nm, "_bresp"}, 32'(e.r), 32'(s_axi_bresp));
    endtask
    // watcher: compares every response as it is taken
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) cmp_read();
        if (s_axi_bvalid && s_axi_bready) cmp_resp();
    end
    initial begin
        #(5.0 * 100000);
        fails++;
        tally_and_finish();
    end
    // =====================================================================
    // bus master; ready raised only on seeing valid, so holding of responses is exercised
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r, input string nm);
        exp_b.push_back('{nm, 32'h0, 32'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                return;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        fails++;
        tally_and_finish();
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r,
                            input string nm);
        exp_r.push_back('{nm, d, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                return;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        fails++;
        tally_and_finish();
    endtask
    function automatic logic [11:0] ch(input int i, input logic [1:0] w);
        return ADDR_CH_BASE + 12'(i << CH_STRIDE_SHIFT) + 12'({w, 2'b00});
    endfunction
    // =====================================================================
    // main sequence
    initial begin
        logic [31:0] d;
        rst_n <= 1'b0; // x to 0 is the edge that fires the async reset
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_read(ADDR_STATUS, 32'h0, '1, RESP_OKAY, "status");
        axi_read(ADDR_OUT_STATE, 32'h0, '1, RESP_OKAY, "out_state");
        axi_read(ADDR_ROUTE, 32'h0, '1, RESP_OKAY, "route");
        axi_read(ADDR_CARD_BASE, 32'(RST_CARD_BASE), '1, RESP_OKAY, "card_base");
        for (int i = 0; i < NUM_INPUTS; i++) begin
            energize <= NUM_INPUTS'($random(seed));
            axi_read(ch(i, CH_CFG), 32'h0, 32'h3, RESP_OKAY, "cfg_rst");
            axi_read(ch(i, CH_DELAY), 32'h0, '1, RESP_OKAY, "delay_rst");
            axi_read(ch(i, CH_COUNT), 32'h0, '1, RESP_OKAY, "count_rst");
            if (i >= BASE_INPUTS)
                axi_read(ch(i, CH_THRESH), {7'h0, RST_REL_V, 7'h0, RST_ACT_V}, 32'h01FF01FF, RESP_OKAY, "thr_rst");
            d = $random(seed);
            axi_write(ch(i, CH_CFG), d & 32'h3, RESP_OKAY, "cfg");
            axi_read(ch(i, CH_CFG), d, 32'h3, RESP_OKAY, "cfg");
            d = $random(seed);
            axi_write(ch(i, CH_DELAY), d, RESP_OKAY, "delay");
            axi_read(ch(i, CH_DELAY), d, '1, RESP_OKAY, "delay");
            if (i >= BASE_INPUTS) begin
                d = $random(seed) & 32'h01FF01FF;
                axi_write(ch(i, CH_THRESH), d, RESP_OKAY, "thr");
                axi_read(ch(i, CH_THRESH), d, 32'h01FF01FF, RESP_OKAY, "thr");
            end
        end
        d = $random(seed);
        axi_write(ADDR_ROUTE, d & 32'h7FF, RESP_OKAY, "route");
        axi_read(ADDR_ROUTE, d, 32'h7FF, RESP_OKAY, "route");
        axi_write(ADDR_CARD_BASE, d & 32'hFF, RESP_OKAY, "card_base");
        axi_read(ADDR_CARD_BASE, d, 32'hFF, RESP_OKAY, "card_base");
        axi_write(ADDR_CLEAR, 32'h7FF, RESP_OKAY, "clear");
        axi_read(ADDR_CLEAR, 32'h0, '1, RESP_OKAY, "clear");
        axi_read(ch(NUM_INPUTS - 1, CH_COUNT), 32'h0, '1, RESP_OKAY, "count_clr");
        axi_read(12'h014, 32'h0, 32'h0, RESP_SLVERR, "unmapped");
        axi_write(12'h014, 32'h1, RESP_SLVERR, "unmapped");
        axi_read(12'h102, 32'h0, 32'h0, RESP_SLVERR, "misaligned");
        // second reset in mid-run must bring back the defaults
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_read(ADDR_CARD_BASE, 32'(RST_CARD_BASE), '1, RESP_OKAY, "card_base_rst2");
        axi_read(ch(3, CH_CFG), 32'h0, 32'h3, RESP_OKAY, "cfg_rst2");
        axi_read(ch(3, CH_DELAY), 32'h0, '1, RESP_OKAY, "delay_rst2");
        repeat (4) @(posedge clk);
        check("pending", 32'h0, 32'(exp_r.size() + exp_b.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== src/discc_channel.sv
// one conditioning channel: threshold, polarity, pick-up and drop-off timing, edge count
`timescale 1ns/1ps
`default_nettype none
module discc_channel
    import discc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // scan tick and field side
    input  wire logic              scan_tick,
    input  wire logic              raw_level,
    input  wire logic              use_volts,
    input  wire logic [VOLT_W-1:0] volts,
    // settings
    input  wire logic              nc_mode,
    input  wire logic              ac_mode,
    input  wire logic [15:0]       on_delay,
    input  wire logic [15:0]       off_delay,
    input  wire logic [8:0]        act_volts,
    input  wire logic [8:0]        rel_volts,
    input  wire logic              count_clear,
    // results
    output logic                   state,
    output logic [31:0]            rise_count
);

    // =====================================================================
    // state
    typedef struct packed {
        logic        energized;
        logic        state;
        logic [15:0] timer;
        logic [31:0] count;
    } discc_ch_t;

    discc_ch_t cur;
    discc_ch_t next_cur;
    logic [8:0]  rel_eff;
    logic [15:0] hold;

    always_comb begin
        next_cur = cur;
        // ac mode forces release to a tenth of activation
        rel_eff  = ac_mode ? 9'(act_volts / 9'h00A) : rel_volts;
        hold     = 16'(off_delay + (ac_mode ? AC_DROP_TICKS : 16'h0000));
        if (scan_tick) begin
            // hysteresis keeps a slowly moving voltage from chattering
            if (!use_volts) begin
                next_cur.energized = raw_level;
            end else if (volts > act_volts) begin
                next_cur.energized = 1'b1;
            end else if (volts < rel_eff) begin
                next_cur.energized = 1'b0;
            end
            if ((next_cur.energized ^ nc_mode) == cur.state) begin
                next_cur.timer = 16'h0000;
            end else if (cur.timer >= (cur.state ? hold : on_delay)) begin
                next_cur.state = ~cur.state;
                next_cur.timer = 16'h0000;
                if (!cur.state) begin
                    next_cur.count = cur.count + 32'h0000_0001;
                end
            end else begin
                next_cur.timer = cur.timer + 16'h0001;
            end
        end
        // a rising edge in the clear cycle is kept as one count
        if (count_clear) begin
            next_cur.count = (scan_tick && next_cur.state && !cur.state) ? 32'h0000_0001 : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign state      = cur.state;
    assign rise_count = cur.count;

endmodule
`default_nettype wire

// ===== src/discc_pkg.sv
// package: register map, field layouts and timing constants of the input scan conditioner
package discc_pkg;

    // =====================================================================
    // timing
    localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
    localparam int unsigned SCAN_PERIOD_US   = 5000;
    localparam int unsigned SCAN_CYCLES      = SCAN_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned AC_DROP_MS       = 30;
    localparam int unsigned SCAN_PERIOD_MS   = 5;
    // ac extra drop-off rounded up to whole scan ticks
    localparam logic [15:0] AC_DROP_TICKS    = 16'((AC_DROP_MS + SCAN_PERIOD_MS - 1) / SCAN_PERIOD_MS);

    // =====================================================================
    // channel counts
    localparam int unsigned BASE_INPUTS      = 3;
    localparam int unsigned CARD_INPUTS      = 8;
    localparam int unsigned NUM_INPUTS       = BASE_INPUTS + CARD_INPUTS;
    localparam int unsigned VOLT_W           = 9;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [11:0] ADDR_STATUS      = 12'h000;
    localparam logic [11:0] ADDR_OUT_STATE   = 12'h004;
    localparam logic [11:0] ADDR_CLEAR       = 12'h008;
    localparam logic [11:0] ADDR_ROUTE       = 12'h00C;
    localparam logic [11:0] ADDR_CARD_BASE   = 12'h010;
    localparam logic [11:0] ADDR_CH_BASE     = 12'h100;
    localparam int unsigned CH_STRIDE_SHIFT  = 4;
    // per-channel word offsets inside a 16-byte slot
    localparam logic [1:0]  CH_CFG           = 2'h0;
    localparam logic [1:0]  CH_DELAY         = 2'h1;
    localparam logic [1:0]  CH_THRESH        = 2'h2;
    localparam logic [1:0]  CH_COUNT         = 2'h3;

    // =====================================================================
    // field positions
    localparam int unsigned CFG_NC_BIT       = 0;
    localparam int unsigned CFG_AC_BIT       = 1;
    localparam int unsigned DLY_ON_LSB       = 0;
    localparam int unsigned DLY_OFF_LSB      = 16;
    localparam int unsigned THR_ACT_LSB      = 0;
    localparam int unsigned THR_REL_LSB      = 16;

    // =====================================================================
    // reset values
    localparam logic [7:0]  RST_CARD_BASE    = 8'h03;
    localparam logic [8:0]  RST_ACT_V        = 9'h058;
    localparam logic [8:0]  RST_REL_V        = 9'h03C;

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// ===== src/discc_top.sv
// top: scan timer, eleven conditioning channels, output routing, axi4-lite registers
// =====================================================================
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module discc_top
    import discc_pkg::*;
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // field inputs
    input  wire logic [BASE_INPUTS-1:0]        base_level,
    input  wire logic [CARD_INPUTS*VOLT_W-1:0] card_volts,
    // internal consumers
    output logic [NUM_INPUTS-1:0]              logic_state,
    output logic [NUM_INPUTS-1:0]              output_relay_contacts,
    output logic                               scan_strobe,
    // axi4-lite write address
    input  wire logic [11:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);

    localparam int unsigned N = NUM_INPUTS;
    // =====================================================================
    // state
    typedef struct packed {
        logic [31:0]  tick_cnt;
        logic         tick;
        logic [N-1:0] logic_q;
        logic [N-1:0] relay_q;
        logic [N-1:0] route;
        logic [7:0]   card_base;
        logic [N-1:0] nc;
        logic [N-1:0] ac;
        logic [N-1:0][15:0] on_dly;
        logic [N-1:0][15:0] off_dly;
        logic [N-1:0][8:0]  act_v;
        logic [N-1:0][8:0]  rel_v;
        logic [N-1:0] clr;
        logic         aw_got;
        logic [11:0]  aw_addr;
        logic         w_got;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } discc_top_t;

    discc_top_t cur;
    discc_top_t next_cur;
    logic [N-1:0]       ch_state;
    logic [N-1:0][31:0] ch_count;

    // channel slot for an address, or N when outside the channel window
    function automatic int unsigned ch_index(input logic [11:0] a);
        int unsigned idx;
        idx = 32'(a - ADDR_CH_BASE) >> CH_STRIDE_SHIFT;
        if (a < ADDR_CH_BASE || idx >= N) begin
            idx = N;
        end
        return idx;
    endfunction

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // =====================================================================
    // channels
    for (genvar i = 0; i < N; i++) begin : g_ch
        logic [VOLT_W-1:0] v;
        logic              raw;
        if (i < BASE_INPUTS) begin : g_base
            assign v   = '0;
            assign raw = base_level[i];
        end else begin : g_card
            assign v   = card_volts[(i-BASE_INPUTS)*VOLT_W +: VOLT_W];
            assign raw = 1'b0;
        end
        // same channel module for base and card inputs; use_volts picks raw level on base, voltage on card
        discc_channel u_ch (
            .clk         (clk),
            .rst_n       (rst_n),
            .scan_tick   (cur.tick),
            .raw_level   (raw),
            .use_volts   (i >= BASE_INPUTS),
            .volts       (v),
            .nc_mode     (cur.nc[i]),
            .ac_mode     (cur.ac[i]),
            .on_delay    (cur.on_dly[i]),
            .off_delay   (cur.off_dly[i]),
            .act_volts   (cur.act_v[i]),
            .rel_volts   (cur.rel_v[i]),
            .count_clear (cur.clr[i]),
            .state       (ch_state[i]),
            .rise_count  (ch_count[i])
        );
    end

    // =====================================================================
    // next state
    always_comb begin
        int unsigned idx;
        logic [31:0] old;
        logic [31:0] nw;
        next_cur = cur;
        idx      = 0;
        old      = 32'h0000_0000;
        nw       = 32'h0000_0000;
        next_cur.clr = '0;

        // scan timer
        if (cur.tick_cnt == 32'(SCAN_CYCLES - 1)) begin
            next_cur.tick_cnt = 32'h0000_0000;
            next_cur.tick     = 1'b1;
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 32'h0000_0001;
            next_cur.tick     = 1'b0;
        end
        // logic state takes the updated channel state at the following tick, relays one tick after that
        if (cur.tick) begin
            next_cur.logic_q = ch_state;
            next_cur.relay_q = cur.logic_q & cur.route;
        end

        // axi write
        if (s_axi_awvalid && !cur.aw_got) begin
            next_cur.aw_got  = 1'b1;
            next_cur.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_got) begin
            next_cur.w_got  = 1'b1;
            next_cur.w_data = s_axi_wdata;
            next_cur.w_strb = s_axi_wstrb;
        end
        if (cur.aw_got && cur.w_got && !cur.bvalid) begin
            next_cur.aw_got = 1'b0;
            next_cur.w_got  = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp  = RESP_OKAY;
            idx = ch_index(cur.aw_addr);
            if (cur.aw_addr == ADDR_CLEAR) begin
                next_cur.clr = cur.w_data[N-1:0] & {N{cur.w_strb != 4'h0}};
            end else if (cur.aw_addr == ADDR_ROUTE) begin
                nw             = merge(32'(cur.route), cur.w_data, cur.w_strb);
                next_cur.route = nw[N-1:0];
            end else if (cur.aw_addr == ADDR_CARD_BASE) begin
                nw                 = merge(32'(cur.card_base), cur.w_data, cur.w_strb);
                next_cur.card_base = nw[7:0];
            end else if (idx < N && cur.aw_addr[1:0] == 2'h0) begin
                case (cur.aw_addr[3:2])
                    CH_CFG: begin
                        old = {30'h0, cur.ac[idx], cur.nc[idx]};
                        nw  = merge(old, cur.w_data, cur.w_strb);
                        next_cur.nc[idx] = nw[CFG_NC_BIT];
                        next_cur.ac[idx] = nw[CFG_AC_BIT];
                    end
                    CH_DELAY: begin
                        nw = merge({cur.off_dly[idx], cur.on_dly[idx]}, cur.w_data, cur.w_strb);
                        next_cur.on_dly[idx]  = nw[DLY_ON_LSB +: 16];
                        next_cur.off_dly[idx] = nw[DLY_OFF_LSB +: 16];
                    end
                    CH_THRESH: begin
                        nw = merge({7'h0, cur.rel_v[idx], 7'h0, cur.act_v[idx]}, cur.w_data, cur.w_strb);
                        next_cur.act_v[idx] = nw[THR_ACT_LSB +: 9];
                        next_cur.rel_v[idx] = nw[THR_REL_LSB +: 9];
                    end
                    default: begin
                        next_cur.bresp = RESP_SLVERR;
                    end
                endcase
            end else begin
                next_cur.bresp = RESP_SLVERR;
            end
        end
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end

        // axi read
        if (s_axi_arvalid && !cur.rvalid) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp  = RESP_OKAY;
            next_cur.rdata  = 32'h0000_0000;
            idx = ch_index(s_axi_araddr);
            if (s_axi_araddr == ADDR_STATUS) begin
                next_cur.rdata = 32'(cur.logic_q);
            end else if (s_axi_araddr == ADDR_OUT_STATE) begin
                next_cur.rdata = 32'(cur.relay_q);
            end else if (s_axi_araddr == ADDR_CLEAR) begin
                next_cur.rdata = 32'h0000_0000;
            end else if (s_axi_araddr == ADDR_ROUTE) begin
                next_cur.rdata = 32'(cur.route);
            end else if (s_axi_araddr == ADDR_CARD_BASE) begin
                next_cur.rdata = 32'(cur.card_base);
            end else if (idx < N && s_axi_araddr[1:0] == 2'h0) begin
                case (s_axi_araddr[3:2])
                    CH_CFG:    next_cur.rdata = {30'h0, cur.ac[idx], cur.nc[idx]};
                    CH_DELAY:  next_cur.rdata = {cur.off_dly[idx], cur.on_dly[idx]};
                    CH_THRESH: next_cur.rdata = {7'h0, cur.rel_v[idx], 7'h0, cur.act_v[idx]};
                    default:   next_cur.rdata = ch_count[idx];
                endcase
            end else begin
                next_cur.rresp = RESP_SLVERR;
            end
        end else if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur           <= '0;
            cur.card_base <= RST_CARD_BASE;
            for (int i = 0; i < N; i++) begin
                cur.act_v[i] <= RST_ACT_V;
                cur.rel_v[i] <= RST_REL_V;
            end
        end else begin
            cur <= next_cur;
        end
    end

    // =====================================================================
    // outputs
    assign logic_state           = cur.logic_q;
    assign output_relay_contacts = cur.relay_q;
    assign scan_strobe           = cur.tick;
    assign s_axi_awready         = !cur.aw_got;
    assign s_axi_wready          = !cur.w_got;
    assign s_axi_bvalid          = cur.bvalid;
    assign s_axi_bresp           = cur.bresp;
    assign s_axi_arready         = !cur.rvalid;
    assign s_axi_rvalid          = cur.rvalid;
    assign s_axi_rdata           = cur.rdata;
    assign s_axi_rresp           = cur.rresp;

endmodule
`default_nettype wire
